// ---- common/smx_params.svh ----
// Constants for the channel select and result readout block
`ifndef SMX_PARAMS_SVH
`define SMX_PARAMS_SVH
`define SMX_WORD_W    32
`define SMX_FIFO_D    8
`define SMX_CMD_W     8
`define SMX_CH_W      3
`define SMX_EN_BIT    3
`define SMX_CNT_W     6
`define SMX_LAST_BIT  6'h1F
`define SMX_MSB       31
`define SMX_SEL_IDLE  1'b1
`endif

// ---- common/smx_pkg.sv ----
// Types shared by the readout block
`include "smx_params.svh"
package smx_pkg;
	typedef enum logic [1:0] {
		SMX_IDLE  = 2'b00,
		SMX_WAIT  = 2'b01,
		SMX_SHIFT = 2'b10,
		SMX_DONE  = 2'b11
	} smx_state_t;

	typedef struct packed {
		smx_state_t                st;
		logic                      sck_d;
		logic                      cs_d;
		logic                      csc_d;
		logic [`SMX_WORD_W-1:0]    sh;
		logic [`SMX_CNT_W-1:0]     bits;
		logic [`SMX_CMD_W-1:0]     cmd_sh;
		logic [`SMX_CH_W:0]        ch_pend;
		logic [`SMX_CH_W-1:0]      ch_out;
		logic                      ch_en;
		logic                      miso;
		logic                      miso_oe;
		logic                      conv_start;
		logic                      pop;
	} smx_top_t;
endpackage

// ---- common/smx_fifo_if.sv ----
// Stream carrier between the readout logic and its result FIFO
`timescale 1ns/100ps
interface smx_fifo_if #(parameter int W = 32);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport user (output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data);
	modport fifo (input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data);
endinterface

// ---- logic/smx_fifo.sv ----
// Result FIFO with registered read data and ready flag
`timescale 1ns/100ps
module smx_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	// Clock, reset and enable
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic ce_in,
	// Stream
	smx_fifo_if.fifo  f
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic [W-1:0]        rd;
		logic                ov;
		logic                rdy;
	} smx_fifo_t;

	smx_fifo_t r;
	smx_fifo_t n;
	logic      push;
	logic      popq;

	always_comb begin
		n = r;
		push = f.in_valid & r.rdy;
		popq = f.out_ready & r.ov;
		if (push) begin
			n.mem[r.wp] = f.in_data;
			n.wp = r.wp + 1'b1;
		end
		if (popq) begin
			n.rp = r.rp + 1'b1;
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(popq);
		n.rdy = (n.cnt != (AW+1)'(D));
		n.ov  = (n.cnt != '0);
		// Head word read from next state, so a write into empty shows
		n.rd  = n.mem[n.rp];
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else if (ce_in) begin
			r <= n;
		end
	end

	assign f.in_ready  = r.rdy;
	assign f.out_valid = r.ov;
	assign f.out_data  = r.rd;
endmodule // smx_fifo

// ---- logic/smx_readout.sv ----
// Channel select and conversion result serial readout, device side
// How it works
// RULE1: host loads channel word before chip select
// RULE2: select low enables interface, connects channel
// RULE3: data line low signals conversion ended
// RULE4: result sent as four bytes, 32 bits
// RULE5: select high floats output, starts conversion
// RULE6: host holds select low whole readout
`timescale 1ns/100ps
`include "smx_params.svh"
module smx_readout (
	// Clock, reset, enable
	input  wire logic                   clk_in,
	input  wire logic                   nrst_in,
	input  wire logic                   ce_in,
	// Serial pins
	input  wire logic                   sck_in,
	input  wire logic                   mosi_in,
	input  wire logic                   converter_select_n_in,
	input  wire logic                   channel_switch_select_n_in,
	output logic                        miso_out,
	output logic                        miso_oe_out,
	// Multiplexer switch control
	output logic [`SMX_CH_W-1:0]        channel_out,
	output logic                        channel_en_out,
	// Converter core
	output logic                        conv_start_out,
	input  wire logic [`SMX_WORD_W-1:0] conv_data_in,
	input  wire logic                   conv_valid_in,
	output logic                        conv_ready_out
);
	import smx_pkg::*;

	// Selects idle high, so their edge history starts high; a low start
	// would show a false select rise and a stray conversion start
	localparam smx_top_t SMX_RST = '{
		st:         SMX_IDLE,
		sck_d:      1'b0,
		cs_d:       `SMX_SEL_IDLE,
		csc_d:      `SMX_SEL_IDLE,
		sh:         '0,
		bits:       '0,
		cmd_sh:     '0,
		ch_pend:    '0,
		ch_out:     '0,
		ch_en:      1'b0,
		miso:       1'b0,
		miso_oe:    1'b0,
		conv_start: 1'b0,
		pop:        1'b0
	};

	// Edges between the last registered level and the present one
	function automatic logic smx_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic smx_fall(input logic cur, input logic prev);
		return ~cur & prev;
	endfunction

	smx_top_t r;
	smx_top_t n;
	logic     sck_rise;
	logic     sck_fall;
	logic     cs_n;
	logic     csc_n;

	smx_fifo_if #(.W(`SMX_WORD_W)) fq ();

	smx_fifo #(
		.W (`SMX_WORD_W),
		.D (`SMX_FIFO_D)
	) u_fifo (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.ce_in   (ce_in),
		.f       (fq)
	);

	assign fq.in_valid  = conv_valid_in;
	assign fq.in_data   = conv_data_in;
	assign fq.out_ready = r.pop;

	always_comb begin
		n = r;
		cs_n  = converter_select_n_in;
		csc_n = channel_switch_select_n_in;
		sck_rise = smx_rise(sck_in, r.sck_d);
		sck_fall = smx_fall(sck_in, r.sck_d);
		n.sck_d = sck_in;
		n.cs_d  = cs_n;
		n.csc_d = csc_n;
		n.conv_start = 1'b0;
		n.pop = 1'b0;

		// Channel word shifts in MSB first on rising edges
		if (!csc_n && sck_rise) begin
			n.cmd_sh = {r.cmd_sh[`SMX_CMD_W-2:0], mosi_in}; // RULE1
		end
		if (smx_rise(csc_n, r.csc_d)) begin
			n.ch_pend = r.cmd_sh[`SMX_CH_W:0]; // RULE1
		end

		if (cs_n) begin
			// Partial readout keeps its word for the next frame
			n.st = SMX_IDLE;
			n.miso_oe = 1'b0; // RULE5
			n.miso = 1'b1;
			n.ch_en = 1'b0;
			if (smx_rise(cs_n, r.cs_d)) begin
				n.conv_start = 1'b1; // RULE5
			end
		end else begin
			case (r.st)
			SMX_IDLE: begin
				if (smx_fall(cs_n, r.cs_d)) begin
					n.ch_out = r.ch_pend[`SMX_CH_W-1:0]; // RULE2
					n.ch_en = r.ch_pend[`SMX_EN_BIT]; // RULE2
					n.miso_oe = 1'b1; // RULE2
					n.miso = 1'b1;
					n.st = SMX_WAIT;
				end
			end
			SMX_WAIT: begin
				// Busy reads high until a result is waiting
				if (fq.out_valid) begin
					n.sh = {1'b0, fq.out_data[`SMX_MSB-1:0]}; // RULE3
					n.miso = 1'b0; // RULE3
					n.bits = '0;
					n.st = SMX_SHIFT;
				end
			end
			SMX_SHIFT: begin
				if (sck_rise) begin
					n.bits = r.bits + 1'b1; // RULE4
					if (r.bits == `SMX_LAST_BIT) begin
						n.pop = 1'b1; // RULE4
						n.st = SMX_DONE;
					end
				end else if (sck_fall) begin
					n.sh = {r.sh[`SMX_WORD_W-2:0], 1'b0}; // RULE4
					n.miso = r.sh[`SMX_WORD_W-2]; // RULE4
				end
			end
			SMX_DONE: begin
				n.miso = 1'b0;
			end
			default: begin
				n.st = SMX_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= SMX_RST;
		end else if (ce_in) begin
			r <= n;
		end
	end

	assign miso_out       = r.miso;
	assign miso_oe_out    = r.miso_oe;
	assign channel_out    = r.ch_out;
	assign channel_en_out = r.ch_en;
	assign conv_start_out = r.conv_start;
	assign conv_ready_out = fq.in_ready;
endmodule // smx_readout

// ---- tb/smx_readout_asserts.sv ----
// Checker on the readout block pins
`timescale 1ns/100ps
module smx_readout_asserts (
	// Clock, reset and pins
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic converter_select_n_in,
	input wire logic miso_out,
	input wire logic miso_oe_out,
	input wire logic conv_start_out
);
	wire c = converter_select_n_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_fall_drive: assert property ($fell(c) |=> miso_oe_out && miso_out)
		else $error("no drive after select fall");
	a_sel_drive: assert property (!c && !$past(c) |-> miso_oe_out)
		else $error("floating while selected");
	a_idle_float: assert property (c |=> !miso_oe_out)
		else $error("driving while deselected");
	a_rise_start: assert property ($rose(c) |=> conv_start_out)
		else $error("no start after select rise");
	cover property ($fell(c) ##[2:400] !miso_out);
	cover property ($rose(c) ##1 conv_start_out);
	cover property (!c [*8]);
endmodule // smx_readout_asserts
bind smx_readout smx_readout_asserts i_smx_readout_asserts (.clk_in,
	.nrst_in, .converter_select_n_in, .miso_out, .miso_oe_out,
	.conv_start_out);

// ---- tb/smx_host.sv ----
// Host serial master model for the readout block
`timescale 1ns/100ps
module smx_host (
	// Clock and device pins
	input wire logic clk_in,
	input wire logic miso_in,
	input wire logic oe_in,
	output logic sck_out = 1'b0,
	output logic mosi_out = 1'b0,
	output logic csc_n_out = 1'b1,
	output logic csm_n_out = 1'b1
);
	// Released line reads inverted, never the stale bit
	wire md = oe_in ? miso_in : ~miso_in;
	task automatic tick(input logic b, input int h, output logic r);
		mosi_out = b;
		repeat (h) @(negedge clk_in);
		r = md;
		sck_out = 1'b1;
		repeat (h) @(negedge clk_in);
		sck_out = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] c, input int h, n,
		output logic [31:0] d, output logic seen);
		logic b;
		int k;
		csm_n_out = 1'b0;
		for (k = 7; k >= 0; k--)
			tick(c[k], h, b);
		csm_n_out = 1'b1;
		repeat (2) @(negedge clk_in);
		csc_n_out = 1'b0;
		// Released line may read low, so the poll needs the drive too
		for (k = 0; k < 300; k++) begin
			if (oe_in === 1'b1 && md === 1'b0)
				break;
			@(negedge clk_in);
		end
		seen = (k < 300);
		for (k = 0; k < n; k++) begin
			tick(!b, h, b);
			d = {d[30:0], b};
		end
		csc_n_out = 1'b1;
	endtask
endmodule // smx_host

// ---- tb/smx_readout_test.sv ----
// Self-checking bench for the readout block
`timescale 1ns/100ps
module smx_readout_test;
	logic clk_in = 1'b0, nrst_in = 1'b0, cv = 1'b0, ce = 1'b1, eoc;
	logic [31:0] cd = '0, q[$], d;
	logic [15:0] lf = 16'h0029;
	wire sck, mosi, cs, csm, so, oe, rdy, en, st;
	wire [2:0] ch;
	int error_cnt = 0, n_checks = 0, i, n_start = 0, en_lo = 0;
	smx_readout i_smx_readout (.clk_in, .nrst_in, .ce_in(ce),
		.sck_in(sck), .mosi_in(mosi), .converter_select_n_in(cs),
		.channel_switch_select_n_in(csm), .miso_out(so),
		.miso_oe_out(oe), .channel_out(ch), .channel_en_out(en),
		.conv_start_out(st), .conv_data_in(cd), .conv_valid_in(cv),
		.conv_ready_out(rdy));
	smx_host i_smx_host (.clk_in, .miso_in(so), .oe_in(oe), .sck_out(sck),
		.mosi_out(mosi), .csc_n_out(cs), .csm_n_out(csm));
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Top bit carries the end of conversion flag, always low
	function automatic logic [31:0] exp_word(input logic [31:0] w);
		return {1'b0, w[30:0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("%0d checks %0d bad", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #4 clk_in = ~clk_in;
	initial begin
		#100000;
		error_cnt++;
		complete_run;
	end
	// Start pulses, and enable drop-outs while a frame is driven
	always @(negedge clk_in) begin
		if (st === 1'b1)
			n_start++;
		if (cs === 1'b0 && oe === 1'b1 && en !== 1'b1)
			en_lo++;
	end
	initial begin
		repeat (8) @(negedge clk_in);
		nrst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		// Offers made while frozen must not land
		ce = 1'b0;
		cv = 1'b1;
		repeat (3) @(negedge clk_in);
		chk("frozen ready", 1'b1, rdy);
		ce = 1'b1;
		// Ninth word meets a full buffer
		for (i = 0; i < 9; i++) begin
			chk("ready", i < 8, rdy);
			lf = nx(lf);
			cd = {lf, ~lf};
			cv = 1'b1;
			q.push_back(exp_word(cd));
			@(negedge clk_in);
		end
		cv = 1'b0;
		$display("fill ended");
		// Aborted read keeps the word queued
		i_smx_host.xfer(8'h0F, 2, 12, d, eoc);
		chk("abort eoc", 1'b1, eoc);
		for (i = 0; i < 8; i++) begin
			lf = nx(lf);
			i_smx_host.xfer({5'h01, lf[2:0]}, 2 + lf[3], 32, d, eoc);
			chk("eoc", 1'b1, eoc);
			chk("word", q.pop_front(), d);
			chk("channel", lf[2:0], ch);
			@(negedge clk_in);
			chk("float", 1'b0, oe);
			chk("enable off", 1'b0, en);
		end
		@(negedge clk_in);
		chk("starts", 9, n_start);
		chk("enable held", 0, en_lo);
		$display("reads ended");
		complete_run;
	end
endmodule // smx_readout_test
